// ### hw/fpoll_consts.svh
// fpoll_consts.svh: offsets, field positions, reset values and timing counts
// of the flash status poll controller.
// assumes a 100 MHz controller clock and a x16 parallel flash bus.
`ifndef FPOLL_CONSTS_SVH
`define FPOLL_CONSTS_SVH

// register byte offsets on the avalon slave
`define FP_OFS_CTRL 4'h0
`define FP_OFS_ADDR 4'h4
`define FP_OFS_STAT 4'h8
`define FP_OFS_NPOLL 4'hc

// control register fields
`define FP_CTRL_GO 0
`define FP_CTRL_OP_LO 1
`define FP_CTRL_EXP_LO 8

// status register fields
`define FP_ST_BUSY 0
`define FP_ST_DONE 1
`define FP_ST_FAIL 2
`define FP_ST_ABORT 3
`define FP_ST_ERRLOCK 4
`define FP_ST_ABTLOCK 5
`define FP_ST_REFUSED 6
`define FP_ST_BYTE_LO 8

// status word bit positions on the low data lanes
`define FP_DQ_POLL 7
`define FP_DQ_TOGGLE 6
`define FP_DQ_ERROR 5
`define FP_DQ_ETIMER 3
`define FP_DQ_ALTTOG 2
`define FP_DQ_BUFABT 1

// command words and command addresses (x16)
`define FP_CMD_RESET 16'h00f0
`define FP_CMD_UNLK1 16'h00aa
`define FP_CMD_UNLK2 16'h0055
`define FP_ADR_UNLK1 12'h555
`define FP_ADR_UNLK2 12'h2aa

// times in ns and derived cycle counts
`define FP_CLK_NS 10
`define FP_T_ACC_NS 110
`define FP_T_GAP_NS 30
`define FP_T_WP_NS 35
`define FP_T_WPH_NS 30
`define FP_T_RP_NS 500
`define FP_T_WAKE_NS 1000
`define FP_CYC_UP(t) (((t) + `FP_CLK_NS - 1) / `FP_CLK_NS)
`define FP_SYNC_CYC 3
`define FP_RD_CYC (`FP_CYC_UP(`FP_T_ACC_NS) + `FP_SYNC_CYC)
`define FP_GAP_CYC `FP_CYC_UP(`FP_T_GAP_NS)
`define FP_WP_CYC `FP_CYC_UP(`FP_T_WP_NS)
`define FP_WPH_CYC `FP_CYC_UP(`FP_T_WPH_NS)
`define FP_RP_CYC `FP_CYC_UP(`FP_T_RP_NS)
`define FP_WAKE_CYC `FP_CYC_UP(`FP_T_WAKE_NS)

// reset values
`define FP_RST_STAT 32'h0000_0000
`define FP_RST_DQ_IN 16'hffff

`endif

// ### hw/fpoll_pkg.sv
// fpoll_pkg: types shared by the flash status poll controller files.
// assumes fpoll_consts.svh holds every number.
package fpoll_pkg;

  // orders that software may give
  typedef enum logic [2:0] {
    OP_POLL_DATA,
    OP_POLL_TOGGLE,
    OP_RESET_F0,
    OP_RESET_FULL,
    OP_RESET_PIN
  } fpoll_op_e;

  // bus sequencer states
  typedef enum logic [2:0] {
    S_IDLE,
    S_RD,
    S_RD_GAP,
    S_WR,
    S_WR_GAP,
    S_RST,
    S_WAKE
  } fpoll_state_e;

  // flash control pins, all active low except the data enable
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic rst_n;
    logic dq_oe;
  } fpoll_pins_s;

endpackage

// ### hw/fpoll_sync.sv
// fpoll_sync: three-stage synchroniser for a bus of pin inputs.
// assumes the inputs are asynchronous to mclk_i; a bit changes at the output
// only once stages two and three agree.
`timescale 1ns/1ns
module fpoll_sync #(
  parameter int W = 16,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_reg; // first stage, read by s2 only
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_next;

  // a bit moves only where stage two and three agree
  assign q_next = (q_o & ~(s2_reg ^ s3_reg)) ^ ((s2_reg ^ q_o) & ~(s2_reg ^ s3_reg)) | (q_o & (s2_reg ^ s3_reg));

  // three flops plus the agreed output
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      q_o <= INIT;
    end
    else
    begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_o <= q_next;
    end
  end
endmodule // fpoll_sync

// ### hw/fpoll_ctrl.sv
// fpoll_ctrl: host controller that polls a parallel nor flash for the end of
// program, erase or blank check and issues the recovery commands.
// assumes one 100 MHz clock, an avalon-mm master with waitrequest, and a x16
// flash whose data lanes are resolved from dq_o and the dq_oe pin enable.
//
// How it works
// - after error, read/reset before any command
// - after abort, full three-write reset sequence; the code also accepts a pin reset instead
// - poll address is programmed or erasing location
// - blank check tracked only by toggle method
// - ignore status bits undefined for operation
`timescale 1ns/1ns
`include "fpoll_consts.svh"
module fpoll_ctrl #(
  parameter int ADDR_W = 26
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [ADDR_W-1:0] flash_addr_o,
  output logic [15:0] flash_dq_o,
  input wire logic [15:0] flash_dq_i,
  output fpoll_pkg::fpoll_pins_s flash_pins_o
);
  fpoll_pkg::fpoll_state_e state_reg, state_next;
  fpoll_pkg::fpoll_op_e op_reg; // order in progress
  logic [1:0] phase_reg; // step inside an order
  logic [15:0] cnt_reg; // cycles left in a bus phase
  logic [7:0] exp_reg; // data written, for the poll bit
  logic [ADDR_W-1:0] paddr_reg; // address to poll
  logic [7:0] stat_reg; // last status word read
  logic [7:0] prev_reg; // earlier status word, toggle method
  logic done_reg, fail_reg, abort_reg, busy_reg, refused_reg;
  logic errlock_reg; // error seen, read/reset owed
  logic abtlock_reg; // abort seen, full reset owed
  logic [15:0] npoll_reg; // reads made by the current order
  logic [15:0] dq_sync; // synchronised data lanes
  // local names for the sequencer states, since the package is never imported
  localparam fpoll_pkg::fpoll_state_e S_IDLE = fpoll_pkg::S_IDLE;
  localparam fpoll_pkg::fpoll_state_e S_RD = fpoll_pkg::S_RD;
  localparam fpoll_pkg::fpoll_state_e S_RD_GAP = fpoll_pkg::S_RD_GAP;
  localparam fpoll_pkg::fpoll_state_e S_WR = fpoll_pkg::S_WR;
  localparam fpoll_pkg::fpoll_state_e S_WR_GAP = fpoll_pkg::S_WR_GAP;
  localparam fpoll_pkg::fpoll_state_e S_RST = fpoll_pkg::S_RST;
  localparam fpoll_pkg::fpoll_state_e S_WAKE = fpoll_pkg::S_WAKE;

  // data lanes come from outside the clock domain
  fpoll_sync #(.W(16), .INIT(`FP_RST_DQ_IN)) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i(flash_dq_i),
    .q_o(dq_sync)
  );

  // avalon decode
  wire bus_wr = avs_write_i & ~avs_waitrequest_o;
  wire bus_req = (avs_read_i | avs_write_i) & avs_waitrequest_o;
  wire wr_ctrl = bus_wr & (avs_address_i == `FP_OFS_CTRL);
  wire wr_addr = bus_wr & (avs_address_i == `FP_OFS_ADDR);
  wire go = wr_ctrl & avs_writedata_i[`FP_CTRL_GO];
  wire [2:0] go_op = avs_writedata_i[`FP_CTRL_OP_LO +: 3];
  wire go_is_poll = (go_op == 3'(fpoll_pkg::OP_POLL_DATA)) | (go_op == 3'(fpoll_pkg::OP_POLL_TOGGLE));
  wire go_is_full = (go_op == 3'(fpoll_pkg::OP_RESET_FULL)) | (go_op == 3'(fpoll_pkg::OP_RESET_PIN));
  wire go_bad_op = go_op > 3'(fpoll_pkg::OP_RESET_PIN);
  // after an error only a reset may go; after an abort only a full reset or a pin reset
  wire go_refuse = busy_reg | go_bad_op | (errlock_reg & go_is_poll) | (abtlock_reg & ~go_is_full);
  wire go_ok = go & ~go_refuse;

  wire [31:0] stat_word = {16'h0000, stat_reg, 1'b0, refused_reg, abtlock_reg, errlock_reg,
                           abort_reg, fail_reg, done_reg, busy_reg};
  wire [31:0] rd_mux = (avs_address_i == `FP_OFS_CTRL) ? {16'h0000, exp_reg, 4'h0, 3'(op_reg), 1'b0} :
                       (avs_address_i == `FP_OFS_ADDR) ? 32'(paddr_reg) :
                       (avs_address_i == `FP_OFS_STAT) ? stat_word :
                       (avs_address_i == `FP_OFS_NPOLL) ? {16'h0000, npoll_reg} : 32'h0000_0000;

  // bus phase ends
  wire cnt_zero = (cnt_reg == 16'h0000);
  wire rd_end = (state_reg == S_RD) & cnt_zero;
  wire [7:0] st = dq_sync[7:0]; // only the low lanes carry status
  wire poll_match = (st[`FP_DQ_POLL] == exp_reg[`FP_DQ_POLL]);
  wire tog_same = (st[`FP_DQ_TOGGLE] == prev_reg[`FP_DQ_TOGGLE]);
  wire st_err = st[`FP_DQ_ERROR];
  wire st_abt = st[`FP_DQ_BUFABT];
  wire is_data = (op_reg == fpoll_pkg::OP_POLL_DATA);
  // verdicts after a read; timer and alt toggle bits are left unread
  wire fin_ok = rd_end & (is_data ? poll_match : (phase_reg != 2'd0 && phase_reg != 2'd2 && tog_same));
  wire fin_bad = rd_end & ~fin_ok & (is_data ? (phase_reg == 2'd1) : (phase_reg == 2'd3));
  wire recheck = rd_end & ~fin_ok & ~fin_bad & (st_err | st_abt);

  // write sequences: single read/reset or unlock, unlock, read/reset
  wire last_wr = (op_reg == fpoll_pkg::OP_RESET_F0) | (phase_reg == 2'd2);
  // op and step of the write about to start: op_reg and phase_reg lag one edge
  // behind a new order and behind a gap, which would move address and data
  // while the write strobe is already low
  wire [2:0] op_cur = go_ok ? go_op : 3'(op_reg);
  wire [1:0] ph_cur = go_ok ? 2'd0 : ((state_reg == S_WR_GAP) ? phase_reg + 2'd1 : phase_reg);
  wire [15:0] wr_data = (op_cur == 3'(fpoll_pkg::OP_RESET_F0) || ph_cur == 2'd2) ? `FP_CMD_RESET :
                        (ph_cur == 2'd0) ? `FP_CMD_UNLK1 : `FP_CMD_UNLK2;
  wire [ADDR_W-1:0] wr_addr_v = (op_cur == 3'(fpoll_pkg::OP_RESET_F0)) ? '0 :
                                (ph_cur == 2'd1) ? ADDR_W'(`FP_ADR_UNLK2) : ADDR_W'(`FP_ADR_UNLK1);
  wire go_rd = go_ok & go_is_poll;
  wire go_wr = go_ok & ((go_op == 3'(fpoll_pkg::OP_RESET_F0)) | (go_op == 3'(fpoll_pkg::OP_RESET_FULL)));
  wire go_pin = go_ok & (go_op == 3'(fpoll_pkg::OP_RESET_PIN));

  // next state of the bus sequencer
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:
      begin
        if (go_rd)
          state_next = S_RD;
        else if (go_wr)
          state_next = S_WR;
        else if (go_pin)
          state_next = S_RST;
      end
      S_RD:
        if (cnt_zero)
          state_next = (fin_ok | fin_bad) ? S_IDLE : S_RD_GAP;
      S_RD_GAP:
        if (cnt_zero)
          state_next = S_RD; // a fresh read each time so the device flips its toggle
      S_WR:
        if (cnt_zero)
          state_next = S_WR_GAP;
      S_WR_GAP:
        if (cnt_zero)
          state_next = last_wr ? S_IDLE : S_WR;
      S_RST:
        if (cnt_zero)
          state_next = S_WAKE;
      S_WAKE:
        if (cnt_zero)
          state_next = S_IDLE;
      default:
        state_next = S_IDLE;
    endcase
  end

  // phase counter load values
  wire [15:0] cnt_load = (state_next == S_RD) ? 16'(`FP_RD_CYC - 1) :
                         (state_next == S_RD_GAP) ? 16'(`FP_GAP_CYC - 1) :
                         (state_next == S_WR) ? 16'(`FP_WP_CYC - 1) :
                         (state_next == S_WR_GAP) ? 16'(`FP_WPH_CYC - 1) :
                         (state_next == S_RST) ? 16'(`FP_RP_CYC - 1) :
                         (state_next == S_WAKE) ? 16'(`FP_WAKE_CYC - 1) : 16'h0000;
  wire enter = (state_next != state_reg) | (cnt_zero & state_reg != S_IDLE);

  // sequencer, counter and pins
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= S_IDLE;
      cnt_reg <= 16'h0000;
      flash_pins_o <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1, dq_oe: 1'b0};
      flash_addr_o <= '0;
      flash_dq_o <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= enter ? cnt_load : cnt_reg - 16'h0001;
      flash_pins_o.ce_n <= ~(state_next == S_RD || state_next == S_WR);
      flash_pins_o.oe_n <= ~(state_next == S_RD);
      flash_pins_o.we_n <= ~(state_next == S_WR);
      flash_pins_o.rst_n <= ~(state_next == S_RST);
      flash_pins_o.dq_oe <= (state_next == S_WR);
      flash_addr_o <= (state_next == S_WR) ? wr_addr_v : paddr_reg;
      flash_dq_o <= wr_data;
    end
  end

  // order bookkeeping and verdicts
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      op_reg <= fpoll_pkg::OP_POLL_DATA;
      phase_reg <= 2'd0;
      exp_reg <= 8'h00;
      paddr_reg <= '0;
      {stat_reg, prev_reg} <= 16'h0000;
      {busy_reg, done_reg, fail_reg, abort_reg, refused_reg} <= 5'h00;
      {errlock_reg, abtlock_reg} <= 2'b00;
      npoll_reg <= 16'h0000;
    end
    else
    begin
      if (wr_addr)
        paddr_reg <= avs_writedata_i[ADDR_W-1:0];
      if (go)
        refused_reg <= go_refuse;
      if (go_ok)
      begin
        op_reg <= fpoll_pkg::fpoll_op_e'(go_op);
        exp_reg <= avs_writedata_i[`FP_CTRL_EXP_LO +: 8];
        phase_reg <= 2'd0;
        npoll_reg <= 16'h0000;
        {busy_reg, done_reg, fail_reg, abort_reg} <= 4'b1000;
      end
      else if (rd_end)
      begin
        stat_reg <= st;
        prev_reg <= st;
        npoll_reg <= npoll_reg + 16'h0001;
        if (fin_ok)
          {busy_reg, done_reg} <= 2'b01;
        else if (fin_bad)
        begin
          {busy_reg, fail_reg} <= 2'b01;
          errlock_reg <= st_err;
          abort_reg <= st_abt & ~st_err;
          abtlock_reg <= st_abt & ~st_err;
        end
        else if (recheck || !is_data)
          // phase 2 always moves on to 3, else a lasting error would reread forever
          phase_reg <= is_data ? 2'd1 : (phase_reg == 2'd2 ? 2'd3 : (recheck ? 2'd2 : 2'd1));
      end
      else if (state_reg == S_WR_GAP && cnt_zero)
      begin
        phase_reg <= phase_reg + 2'd1;
        if (last_wr)
        begin
          {busy_reg, done_reg} <= 2'b01;
          errlock_reg <= 1'b0;
          if (op_reg == fpoll_pkg::OP_RESET_FULL)
            abtlock_reg <= 1'b0;
        end
      end
      else if (state_reg == S_WAKE && cnt_zero)
      begin
        {busy_reg, done_reg} <= 2'b01;
        {errlock_reg, abtlock_reg} <= 2'b00;
      end
    end
  end

  // avalon answer one cycle after the request
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest_o <= ~bus_req;
      if (bus_req)
        avs_readdata_o <= rd_mux;
    end
  end
endmodule // fpoll_ctrl

// ### dv/fpoll_ctrl_checker.sv
// fpoll_ctrl_checker: timing checks on the poll controller's ports.
// assumes it is bound into every fpoll_ctrl and sees one clock domain.
`timescale 1ns/1ns
module fpoll_ctrl_checker #(
  parameter int ADDR_W = 26
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [ADDR_W-1:0] flash_addr_o,
  input wire logic [15:0] flash_dq_o,
  input wire logic [15:0] flash_dq_i,
  input wire fpoll_pkg::fpoll_pins_s flash_pins_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // short names for the strobes
  wire oe_n = flash_pins_o.oe_n;
  wire we_n = flash_pins_o.we_n;
  wire pin_rst_n = flash_pins_o.rst_n;
  // request seen, then a single-cycle answer
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  AST_BUS_ANSWER: assert property (s_req |=> s_ack)
    else $error("bus answer late or long");
  AST_READ_PINS: assert property (!oe_n |-> !flash_pins_o.ce_n && we_n && !flash_pins_o.dq_oe)
    else $error("bad pins in read");
  AST_READ_LEN: assert property ($fell(oe_n) |-> ##13 !oe_n ##1 oe_n)
    else $error("read strobe length wrong");
  AST_READ_GAP: assert property ($rose(oe_n) |-> oe_n [*3])
    else $error("gap between reads short");
  AST_ADDR_HOLD: assert property (!oe_n && $past(!oe_n) |-> $stable(flash_addr_o))
    else $error("address moved in read");
  AST_WRITE_PINS: assert property (!we_n |-> !flash_pins_o.ce_n && oe_n && flash_pins_o.dq_oe)
    else $error("bad pins in write");
  AST_WE_LEN: assert property ($fell(we_n) |-> !we_n [*4] ##1 we_n)
    else $error("write strobe length wrong");
  AST_WE_DATA: assert property (!we_n |=> we_n || $stable(flash_dq_o))
    else $error("write data moved");
  AST_RST_LEN: assert property ($fell(pin_rst_n) |-> ##49 !pin_rst_n ##1 pin_rst_n)
    else $error("reset pulse length wrong");
endmodule // fpoll_ctrl_checker

bind fpoll_ctrl fpoll_ctrl_checker #(.ADDR_W(ADDR_W)) chk_u (
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .flash_addr_o(flash_addr_o),
  .flash_dq_o(flash_dq_o),
  .flash_dq_i(flash_dq_i),
  .flash_pins_o(flash_pins_o)
);

// ### dv/fpoll_flash_model.sv
// fpoll_flash_model: behavioural flash that answers status reads.
// assumes the bench starts each embedded operation through start().
`timescale 1ns/1ns
module fpoll_flash_model (
  input wire logic [15:0] dq_i,
  input wire fpoll_pkg::fpoll_pins_s pins_i,
  output logic [15:0] dq_o
);
  // embedded operation kinds
  localparam logic [2:0] M_ARR = 3'h0, M_PROG = 3'h1, M_ERS = 3'h2;
  localparam logic [2:0] M_BLK = 3'h3, M_PFL = 3'h4, M_ABT = 3'h5, M_SUS = 3'h6;
  logic [2:0] mode = M_ARR; // current operation
  logic [7:0] arr = 8'hff; // array byte at the polled place
  logic [7:0] d = 8'h00; // data being programmed
  logic [7:0] word = 8'h00; // word on the lanes
  logic [7:0] last = 8'h00; // word of the previous read
  logic tg = 1'b0;
  logic at = 1'b0;
  int n = 0; // busy reads left
  int ul = 0; // unlock cycles seen
  // begin an operation lasting k status reads; k=0 never ends
  task automatic start(input logic [2:0] m, input logic [7:0] v, input int k);
    mode = m;
    d = v;
    n = k;
  endtask
  // each read strobe returns status or array data
  always @(negedge pins_i.oe_n)
    if (!pins_i.ce_n && pins_i.rst_n)
    begin
      // a suspended erase freezes the toggle flag
      if (!(mode == M_SUS && n <= 0))
        tg = ~tg;
      at = ~at;
      case (mode)
        M_PROG: word = {~d[7], tg, 6'h00};
        M_ERS: word = {1'b0, tg, 2'h0, 1'b1, at, 2'h0};
        M_BLK: word = {1'b1, tg, 6'h00};
        M_PFL: word = {~d[7], tg, 1'b1, 5'h00};
        M_ABT: word = {~d[7], tg, 4'h0, 1'b1, 1'b0};
        M_SUS: word = {(n <= 0), tg, 3'h0, at, 2'h0};
        default: word = arr;
      endcase
      if (mode inside {M_PROG, M_ERS, M_BLK})
      begin
        n = n - 1;
        if (n == 0)
        begin
          arr = (mode == M_PROG) ? d : 8'hff;
          mode = M_ARR;
        end
      end
      else if (mode == M_SUS && n > 0)
        n = n - 1;
    end
  // remember the word so released lanes can differ from it
  always @(posedge pins_i.oe_n) last = word;
  // no pull-ups: released lanes show the inverse of the last word
  assign dq_o = (!pins_i.ce_n && !pins_i.oe_n && pins_i.rst_n) ? {8'h00, word} : ~{8'h00, last};
  // command words latched as the first of chip enable and write strobe rises;
  // both rise on one edge, so watching the write strobe alone misses commands
  wire wstb_n = pins_i.ce_n | pins_i.we_n;
  always @(posedge wstb_n)
    if (pins_i.oe_n)
      case (dq_i[7:0])
        8'hf0:
        begin
          if (mode == M_PFL || (mode == M_ABT && ul == 2)) mode = M_ARR;
          ul = 0;
        end
        8'haa: ul = 1;
        8'h55: ul = (ul == 1) ? 2 : 0;
        default: ul = 0;
      endcase
  // reset pin ends any operation
  always @(negedge pins_i.rst_n)
  begin
    mode = M_ARR;
    tg = 1'b0;
  end
endmodule // fpoll_flash_model

// ### dv/testbench.sv
// testbench: drives the poll controller over avalon against a flash model.
// assumes fpoll_consts.svh offsets and the checker bound to the design.
`timescale 1ns/1ns
`include "fpoll_consts.svh"
module testbench;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic [31:0] st; // last read value
  logic wreq;
  logic [15:0] dq_o;
  logic [15:0] dq_i;
  logic [15:0] fm_q;
  logic [25:0] fa; // flash address pins
  fpoll_pkg::fpoll_pins_s pins;
  int error_cnt = 0;
  int tests_run = 0;
  always #5 mclk_i = ~mclk_i;
  // wire level: controller while it drives, else the flash
  assign dq_i = pins.dq_oe ? dq_o : fm_q;
  fpoll_ctrl dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .flash_addr_o(fa), .flash_dq_o(dq_o), .flash_dq_i(dq_i), .flash_pins_o(pins));
  fpoll_flash_model fm_u (.dq_i(dq_o), .pins_i(pins), .dq_o(fm_q));
  // verdict and end of run
  task automatic end_of_test;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // masked compare of a register value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    tests_run++;
    if ((got & msk) !== (exp & msk))
    begin
      error_cnt++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // one access, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk_i);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    k = 0;
    do
    begin
      @(posedge mclk_i);
      k++;
    end
    while (wreq !== 1'b0 && k < 50);
    st = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wreq !== 1'b0)
    begin
      error_cnt++;
      end_of_test;
    end
  endtask
  // give an order and poll status until busy drops
  task automatic run(input logic [2:0] op, input logic [7:0] e);
    int k;
    acc(1'b1, `FP_OFS_CTRL, {16'h0000, e, 4'h0, op, 1'b1});
    k = 0;
    do
    begin
      acc(1'b0, `FP_OFS_STAT, 32'h0);
      k++;
    end
    while (st[`FP_ST_BUSY] !== 1'b0 && k < 2000);
    if (k >= 2000)
    begin
      error_cnt++;
      end_of_test;
    end
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    acc(1'b0, `FP_OFS_STAT, 32'h0);
    chk(st, `FP_RST_STAT, 32'hffff_ffff);
    acc(1'b0, 4'h2, 32'h0);
    chk(st, 32'h0, 32'hffff_ffff);
    $display("test reset done");
    // program ending after three busy reads
    fm_u.start(3'h1, 8'h5a, 3);
    acc(1'b1, `FP_OFS_ADDR, 32'h100);
    run(3'h0, 8'h5a);
    chk(st, 32'h5a02, 32'hff07);
    acc(1'b0, `FP_OFS_NPOLL, 32'h0);
    chk(st, 32'h4, 32'hffff_ffff);
    acc(1'b0, `FP_OFS_ADDR, 32'h0);
    chk(st, 32'h100, 32'hffff_ffff);
    chk({6'h00, fa}, 32'h100, 32'hffff_ffff);
    acc(1'b0, `FP_OFS_CTRL, 32'h0);
    chk(st, 32'h5a00, 32'hffff_ffff);
    $display("test program done");
    // erase by toggle, blank check by toggle, erase by data poll
    fm_u.start(3'h2, 8'hff, 4);
    run(3'h1, 8'hff);
    chk(st, 32'hff02, 32'hff07);
    fm_u.start(3'h3, 8'h00, 2);
    run(3'h1, 8'h00);
    chk(st, 32'h0002, 32'h0007);
    fm_u.start(3'h2, 8'hff, 3);
    run(3'h0, 8'h80);
    chk(st, 32'h8002, 32'h8007);
    // erase suspend: toggle stops, then poll bit reads 1
    fm_u.start(3'h6, 8'hff, 2);
    run(3'h1, 8'h80);
    chk(st, 32'h0002, 32'h0007);
    fm_u.start(3'h6, 8'hff, 2);
    run(3'h0, 8'h80);
    chk(st, 32'h8002, 32'h8007);
    $display("test erase done");
    // failure: lock, refused poll, single reset clears
    fm_u.start(3'h4, 8'h5a, 0);
    run(3'h0, 8'h5a);
    chk(st, 32'ha014, 32'ha215);
    run(3'h0, 8'h5a);
    chk(st, 32'h0040, 32'h0040);
    run(3'h2, 8'h00);
    chk(st, 32'h0000, 32'h0010);
    chk({29'h0, fm_u.mode}, 32'h0, 32'h7);
    // toggle poll of a failing program ends in fail and lock
    fm_u.start(3'h4, 8'h5a, 0);
    run(3'h1, 8'h00);
    chk(st, 32'h0014, 32'h0015);
    run(3'h2, 8'h00);
    $display("test error done");
    // abort: single reset refused, full sequence clears
    fm_u.start(3'h5, 8'h33, 0);
    run(3'h0, 8'h33);
    chk(st, 32'h822c, 32'ha22d);
    run(3'h2, 8'h00);
    chk(st, 32'h0040, 32'h0040);
    run(3'h3, 8'h00);
    chk(st, 32'h0000, 32'h0020);
    chk({29'h0, fm_u.mode}, 32'h0, 32'h7);
    $display("test abort done");
    // pin reset ends a long program
    fm_u.start(3'h1, 8'h11, 100);
    run(3'h4, 8'h00);
    chk(st, 32'h0002, 32'h0037);
    chk({29'h0, fm_u.mode}, 32'h0, 32'h7);
    $display("test pin reset done");
    end_of_test;
  end
endmodule // testbench
